// *** verilog/ptps_pkg.sv ***
// package: register map, field layout and types of the period timer
package ptps_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FLAG   = 8'h0C; // event flags, read/write
	localparam logic [7:0] IDX_CLEAR  = 8'h0D; // write one to clear a flag
	localparam logic [7:0] IDX_IEN    = 8'h0E; // interrupt enables
	localparam logic [7:0] IDX_COUNT  = 8'h11; // running count
	localparam logic [7:0] IDX_CTRL   = 8'h12; // timer control
	localparam logic [7:0] IDX_PERIOD = 8'h13; // period limit

	// control field positions
	localparam int unsigned CTRL_PRE_LSB  = 0; // input divide select
	localparam int unsigned CTRL_RUN_BIT  = 2; // counter run
	localparam int unsigned CTRL_POST_LSB = 3; // output divide select
	localparam logic [7:0]  CTRL_WMASK    = 8'h7F; // top bit unimplemented

	// flag positions
	localparam int unsigned FLAG_MATCH_BIT = 0; // raw period match
	localparam int unsigned FLAG_EVT_BIT   = 1; // period event flag
	localparam int unsigned FLAG_W         = 2; // implemented flag bits

	// reset values
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] COUNT_RST  = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	localparam logic [1:0] FLAG_RST   = 2'h0;
	localparam logic [1:0] IEN_RST    = 2'h0;

	// timing counts, in oscillator cycles and instruction ticks
	localparam logic [1:0] OSC_DIV_LAST = 2'h3; // divide by four
	localparam logic [3:0] PRE_LAST_1   = 4'h0; // 1:1
	localparam logic [3:0] PRE_LAST_4   = 4'h3; // 1:4
	localparam logic [3:0] PRE_LAST_16  = 4'hF; // 1:16

	// input divide encodings
	typedef enum logic [1:0] {
		PRE_1   = 2'b00,
		PRE_4   = 2'b01,
		PRE_16A = 2'b10,
		PRE_16B = 2'b11
	} ptps_pre_type;

	// control register layout
	typedef struct packed {
		logic         spare;  // always zero
		logic [3:0]   post;   // output divide select
		logic         run;    // counter run
		ptps_pre_type pre;    // input divide select
	} ptps_ctrl_type;

	// captured bus address phase
	typedef struct packed {
		logic       valid;    // a transfer to this slave
		logic       write;    // direction
		logic [7:0] idx;      // register index
	} ptps_aphase_type;

endpackage : ptps_pkg

// *** verilog/ptps_timer.sv ***
// period timer with input and output dividers behind an AHB-Lite slave
// Operation
// - eight-bit count, read/write, zero after reset
// - instruction clock, input divide 1, 4, 16
// - counts up, wraps to zero after period match
// - eight-bit period register, read/write, resets all ones
// - output divider 1..16 sets period event flag
// - run bit clear stops and holds count
// - control clears on reset: stopped, both 1:1
// - divider counters clear on count/control write, reset
// - control write leaves count untouched
// - match pulse before output divide goes out
// - control register at index 12h, eight bits
// - control top bit ignores writes, reads zero
//
// The implementer's own choice: register access over AHB-Lite.
module ptps_timer (
	input  wire logic        hclk,          // oscillator clock
	input  wire logic        hresetn,       // async reset, active low
	input  wire logic        hsel,          // slave select
	input  wire logic [31:0] haddr,         // byte address
	input  wire logic [1:0]  htrans,        // transfer type
	input  wire logic        hwrite,        // write when high
	input  wire logic [2:0]  hsize,         // transfer size
	input  wire logic [31:0] hwdata,        // write data
	input  wire logic        hready,        // bus ready
	output logic             hreadyout,     // slave ready, always high
	output logic [31:0]      hrdata,        // read data
	output logic             hresp,         // always okay
	output logic             irq,           // level interrupt
	output logic             sync_serial_port_tick // match pulse out
);

	// bus state
	ptps_pkg::ptps_aphase_type aphase_q;    // held address phase
	ptps_pkg::ptps_aphase_type aphase_d;    // next address phase
	logic [31:0]               rdata_q;     // registered read data
	logic [31:0]               rdata_d;     // read data next
	logic                      hresp_q;     // response flop

	// timer state
	ptps_pkg::ptps_ctrl_type   ctrl_q;      // timer control
	logic [7:0]                count_q;     // count value
	logic [7:0]                count_d;
	logic [7:0]                period_q;    // period limit
	logic [1:0]                osc_div_q;   // oscillator divide by four
	logic [3:0]                pre_cnt_q;   // input divider counter
	logic [3:0]                pre_cnt_d;
	logic [3:0]                post_cnt_q;  // output divider counter
	logic [3:0]                post_cnt_d;
	logic                      match_q;     // exported match pulse
	logic [1:0]                flag_q;      // sticky event flags
	logic [1:0]                flag_d;
	logic [1:0]                ien_q;       // interrupt enables
	logic                      irq_q;       // interrupt level flop

	// decode wires
	logic                      sel_addr;    // address phase accepted
	logic                      wr_act;      // data phase write
	logic                      cnt_wr;      // write to count
	logic                      ctrl_wr;     // write to control
	logic                      per_wr;      // write to period
	logic                      flag_wr;     // write to flags
	logic                      clr_wr;      // write to clear
	logic                      ien_wr;      // write to enables
	logic                      instr_en;    // instruction clock enable
	logic [3:0]                pre_last;    // input divider terminal
	logic                      tick;        // count increment event
	logic                      at_period;   // count equals period
	logic                      match;       // period match event
	logic                      post_hit;    // output divider terminal
	logic                      scale_clr;   // clear both dividers
	logic [1:0]                evt;         // hardware flag sets
	logic [1:0]                clr_mask;    // software flag clears
	logic [7:0]                rd_idx;      // read index
	logic                      in_range;    // upper address bits zero

	// address phase decode; the index bits select a register, the upper bits must be zero
	assign sel_addr = hsel & hready & htrans[1];
	assign rd_idx   = haddr[9:2];
	assign in_range = (haddr[31:10] == 22'h0);
	assign aphase_d = '{valid: sel_addr & in_range,
	                    write: hwrite,
	                    idx:   rd_idx};

	// data phase write strobes
	assign wr_act  = aphase_q.valid & aphase_q.write;
	assign cnt_wr  = wr_act & (aphase_q.idx == ptps_pkg::IDX_COUNT);
	assign ctrl_wr = wr_act & (aphase_q.idx == ptps_pkg::IDX_CTRL);
	assign per_wr  = wr_act & (aphase_q.idx == ptps_pkg::IDX_PERIOD);
	assign flag_wr = wr_act & (aphase_q.idx == ptps_pkg::IDX_FLAG);
	assign clr_wr  = wr_act & (aphase_q.idx == ptps_pkg::IDX_CLEAR);
	assign ien_wr  = wr_act & (aphase_q.idx == ptps_pkg::IDX_IEN);

	// read mux, sampled in the address phase so data stands with no wait;
	// unmapped indices read zero and reserved bits read zero
	assign rdata_d =
		!(sel_addr & in_range & !hwrite) ? 32'h00000000 :
		(rd_idx == ptps_pkg::IDX_COUNT)  ? {24'h000000, count_q} :
		(rd_idx == ptps_pkg::IDX_CTRL)   ? {24'h000000, ctrl_q} :
		(rd_idx == ptps_pkg::IDX_PERIOD) ? {24'h000000, period_q} :
		(rd_idx == ptps_pkg::IDX_FLAG)   ? {30'h0, flag_q} :
		(rd_idx == ptps_pkg::IDX_IEN)    ? {30'h0, ien_q} :
		32'h00000000;

	// bus flops; the slave never stretches a transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aphase_q <= '0;
			rdata_q  <= 32'h00000000;
			hresp_q  <= 1'b0;
		end else begin
			aphase_q <= hready ? aphase_d : aphase_q;
			rdata_q  <= rdata_d;
			hresp_q  <= 1'b0;
		end
	end

	// control register; top bit is masked so it stays zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= ptps_pkg::CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_q <= hwdata[7:0] & ptps_pkg::CTRL_WMASK;
		end
	end

	// period register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_q <= ptps_pkg::PERIOD_RST;
		end else if (per_wr) begin
			period_q <= hwdata[7:0];
		end
	end

	// oscillator divided by four gives the instruction clock enable;
	// it free-runs so the phase of ticks is not tied to software writes
	assign instr_en = (osc_div_q == ptps_pkg::OSC_DIV_LAST);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_div_q <= 2'h0;
		end else begin
			osc_div_q <= osc_div_q + 2'h1;
		end
	end

	// input divider terminal count from the select field
	assign pre_last =
		(ctrl_q.pre == ptps_pkg::PRE_1) ? ptps_pkg::PRE_LAST_1 :
		(ctrl_q.pre == ptps_pkg::PRE_4) ? ptps_pkg::PRE_LAST_4 :
		ptps_pkg::PRE_LAST_16;

	// a write to count or control restarts both dividers
	assign scale_clr = cnt_wr | ctrl_wr;

	// increment event: run bit gates the chain after the oscillator divider to save power
	assign tick = ctrl_q.run & instr_en & (pre_cnt_q == pre_last);

	// input divider counter
	assign pre_cnt_d =
		scale_clr                 ? 4'h0 :
		!(ctrl_q.run & instr_en)  ? pre_cnt_q :
		tick                      ? 4'h0 :
		pre_cnt_q + 4'h1;

	// count: a software write wins over an increment in the same cycle
	assign at_period = (count_q == period_q);
	assign match     = tick & at_period & !cnt_wr;
	assign count_d   =
		cnt_wr ? hwdata[7:0] :
		!tick  ? count_q :
		at_period ? 8'h00 :
		count_q + 8'h01;

	// output divider: ratio is field value plus one
	assign post_hit   = match & (post_cnt_q == ctrl_q.post);
	assign post_cnt_d =
		scale_clr ? 4'h0 :
		!match    ? post_cnt_q :
		post_hit  ? 4'h0 :
		post_cnt_q + 4'h1;

	// counting flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q    <= ptps_pkg::COUNT_RST;
			pre_cnt_q  <= 4'h0;
			post_cnt_q <= 4'h0;
			match_q    <= 1'b0;
		end else begin
			count_q    <= count_d;
			pre_cnt_q  <= pre_cnt_d;
			post_cnt_q <= post_cnt_d;
			match_q    <= match;
		end
	end

	// flags: hardware sets win over any software clear in the same cycle
	assign evt = {post_hit, match};
	assign clr_mask = clr_wr ? hwdata[1:0] : 2'h0;
	assign flag_d =
		((flag_wr ? hwdata[1:0] : flag_q) & ~clr_mask) | evt;

	// flag, enable and interrupt flops; irq lags the flag by one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= ptps_pkg::FLAG_RST;
			ien_q  <= ptps_pkg::IEN_RST;
			irq_q  <= 1'b0;
		end else begin
			flag_q <= flag_d;
			ien_q  <= ien_wr ? hwdata[1:0] : ien_q;
			irq_q  <= |(flag_q & ien_q);
		end
	end

	// outputs straight from flops
	assign hreadyout             = 1'b1 | hresp_q;
	assign hrdata                = rdata_q;
	assign hresp                 = hresp_q;
	assign irq                   = irq_q;
	assign sync_serial_port_tick = match_q;

	// checks; they watch the flops and the decode wires directly so that
	// a failure points at the stage that broke, not at the bus outputs.
	// the bus side is kept out on purpose: the slave answers with no wait
	// and its behaviour is exercised end to end by the bench.
	// every check is quiet while reset is low, since the dividers and the
	// flags are forced there and their history means nothing
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_wrap_to_zero: assert property (
		tick && at_period && !cnt_wr |=> count_q == 8'h00)
		else $error("count did not wrap to zero at period");

	a_count_step: assert property (
		tick && !at_period && !cnt_wr |=> count_q == $past(count_q) + 8'h01)
		else $error("count did not step by one");

	a_hold_stopped: assert property (
		!ctrl_q.run && !cnt_wr |=> $stable(count_q))
		else $error("count moved while stopped");

	a_ctrl_keeps_count: assert property (
		ctrl_wr && !tick |=> $stable(count_q))
		else $error("control write changed count");

	a_scalers_cleared: assert property (
		cnt_wr || ctrl_wr |=> pre_cnt_q == 4'h0 && post_cnt_q == 4'h0)
		else $error("dividers not cleared by write");

	a_top_bit_zero: assert property (
		ctrl_wr && hwdata[7] |=> ctrl_q.spare == 1'b0)
		else $error("control top bit stored");

	a_event_flag_set: assert property (
		match && post_cnt_q == ctrl_q.post
		|=> flag_q[1] ##1 irq == $past(ien_q[1]))
		else $error("event flag not set at divider end");

	a_match_export: assert property (
		match |=> sync_serial_port_tick ##1 !sync_serial_port_tick)
		else $error("match pulse not exported for one cycle");

	a_flag_sticky: assert property (
		flag_q[1] && !clr_wr && !flag_wr |=> flag_q[1])
		else $error("event flag dropped without software");

	a_tick_spacing: assert property (
		tick |=> !tick [*3])
		else $error("increments closer than the instruction clock");

	a_fast_divide: assert property (
		tick && ctrl_q.pre == ptps_pkg::PRE_1 && !scale_clr
		|=> !tick [*3] ##1 (tick || !ctrl_q.run || scale_clr ||
		                    $past(scale_clr) || ctrl_q.pre != ptps_pkg::PRE_1))
		else $error("1:1 divide did not tick every instruction");

	// input divider steps by one between increments while running
	a_pre_step: assert property (
		ctrl_q.run && instr_en && pre_cnt_q != pre_last && !scale_clr
		|=> pre_cnt_q == $past(pre_cnt_q) + 4'h1)
		else $error("input divider did not step");

	// output divider restarts after its terminal count
	a_post_restart: assert property (
		post_hit && !scale_clr |=> post_cnt_q == 4'h0)
		else $error("output divider did not restart");

	// a software count write lands as written
	a_count_write: assert property (
		cnt_wr |=> count_q == $past(hwdata[7:0]))
		else $error("count write not stored");

	// a period write lands as written
	a_period_write: assert property (
		per_wr |=> period_q == $past(hwdata[7:0]))
		else $error("period write not stored");

	// period only moves on a software write
	a_period_hold: assert property (
		!per_wr |=> $stable(period_q))
		else $error("period changed without a write");

	// control only moves on a software write
	a_ctrl_hold: assert property (
		!ctrl_wr |=> $stable(ctrl_q))
		else $error("control changed without a write");

	// a match only comes with an increment event
	a_match_on_tick: assert property (
		match |-> tick)
		else $error("match without an increment");

	// no increment event while the run bit is clear
	a_stopped_quiet: assert property (
		!ctrl_q.run |-> !tick)
		else $error("increment while stopped");

	// a software clear drops the event flag unless an event hits
	a_flag_clear: assert property (
		clr_wr && hwdata[1] && !post_hit |=> !flag_q[1])
		else $error("event flag not cleared");

	// a software write may set the event flag
	a_flag_soft_set: assert property (
		flag_wr && hwdata[1] |=> flag_q[1])
		else $error("event flag not set by software");

	// interrupt level follows enabled flags one cycle later
	a_irq_follows: assert property (
		1'b1 |=> irq == |($past(flag_q) & $past(ien_q)))
		else $error("interrupt level wrong");

endmodule : ptps_timer

// *** verif/ptps_timer_tb_top.sv ***
// self-checking testbench of the period timer over its bus slave
module ptps_timer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        hclk;      // 200 MHz clock
	logic        hresetn;   // active low reset
	logic        hsel;      // slave select
	logic [31:0] haddr;     // byte address
	logic [1:0]  htrans;    // transfer type
	logic        hwrite;    // direction
	logic [2:0]  hsize;     // always word
	logic [31:0] hwdata;    // write data
	logic        hreadyout; // slave ready, fed back as hready
	logic [31:0] hrdata;    // read data
	logic        hresp;     // response
	logic        irq;       // level interrupt
	logic        tick;      // match pulse
	logic [31:0] v;         // read scratch
	logic [31:0] w;         // second read scratch
	int          seed;      // random seed
	int          error_cnt; // mismatches
	int          n_tests;   // comparisons
	int          cyc;       // timeout counter
	int          tick_cnt;  // match pulses seen
	int          t0;        // pulse count base
	int          n;         // measured cycles
	logic [3:0]  post;      // output divide field

	ptps_timer i_ptps_timer (
		.hclk                  (hclk),
		.hresetn               (hresetn),
		.hsel                  (hsel),
		.haddr                 (haddr),
		.htrans                (htrans),
		.hwrite                (hwrite),
		.hsize                 (hsize),
		.hwdata                (hwdata),
		.hready                (hreadyout),
		.hreadyout             (hreadyout),
		.hrdata                (hrdata),
		.hresp                 (hresp),
		.irq                   (irq),
		.sync_serial_port_tick (tick)
	);

	// clock generator
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// count match pulses once per cycle
	always @(posedge hclk) begin
		if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
	end

	// hang guard; the whole run needs far fewer cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// one ahb single transfer; ready and read data taken at the edge itself
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// register write and read shorthands
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rdr(input logic [7:0] idx, output logic [31:0] d);
		bus(1'b0, idx, 32'h0, d);
	endtask : rdr

	// compare and report
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	// cycles to the next match pulse, bounded
	task automatic wait_tick(output int c);
		c = 0;
		do begin
			@(posedge hclk);
			#1;
			c++;
		end while (tick !== 1'b1 && c < 5000);
	endtask : wait_tick

	// input divide ratio expected for a select code
	function automatic int ratio(input logic [1:0] p);
		return (p == 2'h0) ? 1 : ((p == 2'h1) ? 4 : 16);
	endfunction : ratio

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	initial begin
		seed = 28;
		{error_cnt, n_tests, cyc, tick_cnt} = '0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values and an unmapped index
		rdr(ptps_pkg::IDX_COUNT, v);
		chk("count", 32'h0, v);
		rdr(ptps_pkg::IDX_CTRL, v);
		chk("ctrl", 32'h0, v);
		rdr(ptps_pkg::IDX_PERIOD, v);
		chk("period", 32'hFF, v);
		wr(8'h20, 32'hFF);
		rdr(8'h20, v);
		chk("unmapped", 32'h0, v);
		$display("test reset values done");
		// random read/write; top control bit must stay zero, run kept off
		for (int i = 0; i < 4; i++) begin
			w = $random(seed);
			wr(ptps_pkg::IDX_PERIOD, w);
			rdr(ptps_pkg::IDX_PERIOD, v);
			chk("period", {24'h0, w[7:0]}, v);
			wr(ptps_pkg::IDX_COUNT, w >> 8);
			rdr(ptps_pkg::IDX_COUNT, v);
			chk("count", {24'h0, w[15:8]}, v);
			wr(ptps_pkg::IDX_CTRL, (w & 32'hFB) | 32'h80);
			rdr(ptps_pkg::IDX_CTRL, v);
			chk("ctrl", {24'h0, w[7:0] & 8'h7B}, v);
		end
		// control write keeps count
		wr(ptps_pkg::IDX_COUNT, 32'h5A);
		wr(ptps_pkg::IDX_CTRL, 32'h78);
		rdr(ptps_pkg::IDX_COUNT, v);
		chk("count", 32'h5A, v);
		// stop holds the count
		wr(ptps_pkg::IDX_CTRL, 32'h04);
		repeat (50) @(posedge hclk);
		wr(ptps_pkg::IDX_CTRL, 32'h00);
		rdr(ptps_pkg::IDX_COUNT, w);
		repeat (200) @(posedge hclk);
		rdr(ptps_pkg::IDX_COUNT, v);
		chk("held count", w, v);
		$display("test access done");
		// match pulse spacing for every input divide code, period 3
		wr(ptps_pkg::IDX_PERIOD, 32'h03);
		wr(ptps_pkg::IDX_COUNT, 32'h00);
		for (int p = 0; p < 4; p++) begin
			wr(ptps_pkg::IDX_CTRL, 32'h04 | p);
			wait_tick(n);
			wait_tick(n);
			chk("tick gap", 16 * ratio(p), n);
			rdr(ptps_pkg::IDX_COUNT, v);
			chk("count range", 32'h1, {31'h0, v <= 32'h3});
		end
		$display("test divide done");
		// output divide: boundaries then random
		wr(ptps_pkg::IDX_IEN, 32'h2);
		for (int k = 0; k < 4; k++) begin
			post = (k == 0) ? 4'h0 : ((k == 1) ? 4'hF : 4'($random(seed)));
			wr(ptps_pkg::IDX_CTRL, 32'h00);
			wr(ptps_pkg::IDX_CLEAR, 32'h3);
			wr(ptps_pkg::IDX_COUNT, 32'h00);
			wr(ptps_pkg::IDX_CTRL, {25'h0, post, 3'h4});
			t0 = tick_cnt;
			n = 0;
			while (irq !== 1'b1 && n < 5000) begin
				@(posedge hclk);
				#1;
				n++;
			end
			chk("matches to flag", post + 1, tick_cnt - t0);
		end
		// clearing drops the interrupt
		wr(ptps_pkg::IDX_CTRL, 32'h00);
		wr(ptps_pkg::IDX_CLEAR, 32'h3);
		repeat (3) @(posedge hclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// software set, masked then enabled
		wr(ptps_pkg::IDX_IEN, 32'h0);
		wr(ptps_pkg::IDX_FLAG, 32'h2);
		repeat (3) @(posedge hclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(ptps_pkg::IDX_IEN, 32'h2);
		repeat (3) @(posedge hclk);
		chk("irq soft", 32'h1, {31'h0, irq});
		rdr(ptps_pkg::IDX_FLAG, v);
		chk("flag sticky", 32'h1, {31'h0, v[1]});
		$display("test interrupt done");
		// reset with the timer stopped brings count and period back
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdr(ptps_pkg::IDX_COUNT, v);
		chk("count after reset", 32'h0, v);
		rdr(ptps_pkg::IDX_PERIOD, v);
		chk("period after reset", 32'hFF, v);
		$display("test second reset done");
		report_and_stop();
	end
endmodule : ptps_timer_tb_top
